// >>> rtl/iof_pkg.sv
// package: constants and carriers for the i/o sample frame builder
package iof_pkg;
    // ********************************
    // frame layout
    // ********************************
    localparam int         IW          = 6;     // byte index width
    localparam logic [7:0] SOF_BYTE    = 8'h7e; // start delimiter
    localparam logic [7:0] TYPE_A64    = 8'h82; // sample set, 64-bit source
    localparam logic [7:0] TYPE_A16    = 8'h83; // sample set, 16-bit source
    localparam logic [7:0] CKSUM_BASE  = 8'hff;
    localparam logic [IW-1:0] OFS_SOF  = 6'h00;
    localparam logic [IW-1:0] OFS_LENH = 6'h01;
    localparam logic [IW-1:0] OFS_LENL = 6'h02;
    localparam logic [IW-1:0] OFS_TYPE = 6'h03;
    localparam logic [IW-1:0] OFS_ADDR = 6'h04;
    localparam logic [IW-1:0] OFS_RSSI64 = 6'h0c;
    localparam logic [IW-1:0] OFS_RSSI16 = 6'h06;
    localparam logic [IW-1:0] OFS_DIG64  = 6'h11;
    localparam logic [IW-1:0] OFS_DIG16  = 6'h0b;
    localparam logic [IW-1:0] OFS_AN64   = 6'h13;
    localparam logic [IW-1:0] OFS_AN16   = 6'h0d;
    // ********************************
    // channel mask / digital word fields
    // ********************************
    localparam int DIG_LSB = 0;   // digital_line_bits
    localparam int DIG_W   = 9;
    localparam int AN_LSB  = 9;   // analog_channel_bits
    localparam int AN_N    = 4;
    localparam int ADC_W   = 10;
    localparam int OPT_ADDR_BC = 1;
    localparam int OPT_PAN_BC  = 2;
    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic                       is64;
        logic [63:0]                src_addr;
        logic [7:0]                 rssi_mag;
        logic                       addr_bcast;
        logic                       pan_bcast;
        logic [7:0]                 nsamples;
        logic [15:0]                chan_mask;
        logic [15:0]                dig_word;
        logic [AN_N-1:0][ADC_W-1:0] adc;
    } iof_sample_t;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } iof_byte_t;
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } iof_state_t;
endpackage

// >>> rtl/iof_cksum.sv
// module: running checksum over the frame data bytes
module iof_cksum (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       srst,
    // accumulate control
    input  wire logic       clr,
    input  wire logic       add,
    input  wire logic [7:0] din,
    // result
    output logic [7:0]      ck_byte
);
    import iof_pkg::*;
    logic [7:0] sum;

    // modulo-256 sum; clear wins because it marks a fresh frame
    always_ff @(posedge mclk) begin
        if (srst || clr) begin
            sum <= 8'h00;
        end else if (add) begin
            sum <= sum + din;
        end
    end

    assign ck_byte = CKSUM_BASE - sum;
endmodule

// >>> rtl/iof_frame_builder.sv
// module: builds i/o sample set frames as a byte stream toward the uart
// Overview of operation
// - 64-bit source gives type 0x82, address msb-first
// - offset 12 holds signal strength magnitude
// - options bit1 address bcast, bit2 pan bcast
// - 64-bit frame: sample count at offset 14
// - two-byte channel mask, msb first, 15-16
// - mask and digital word share one layout
// - digital word present when any line enabled
// - disabled lines read zero; none enabled omits word
// - two bytes per enabled analog input, msb first
// - analog is 10-bit, upper six bits zero
// - analog words in ascending channel order
// - 16-bit source gives type 0x83, two-byte address
// - 16-bit: strength 6, options 7, count 8, mask 9-10
// - 16-bit: digital at 11-12, analog from 13
module iof_frame_builder (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 srst,
    // sample set from the radio side
    input  wire iof_pkg::iof_sample_t smp_in,
    input  wire logic                 smp_valid,
    output logic                      smp_ready,
    // byte stream toward the uart
    output iof_pkg::iof_byte_t        tx,
    input  wire logic                 tx_ready
);
    import iof_pkg::*;

    // ********************************
    // state
    // ********************************
    iof_state_t  state;
    iof_sample_t smp;
    logic [IW-1:0] idx;
    logic        accept;
    logic        slot_free;
    logic        load;
    logic        fin;

    assign smp_ready = (state == ST_IDLE);
    assign accept    = smp_valid && smp_ready;
    assign slot_free = !tx.valid || tx_ready;

    // ********************************
    // layout decode
    // ********************************
    logic [IW-1:0] rssi_idx;
    logic [IW-1:0] opt_idx;
    logic [IW-1:0] cnt_idx;
    logic [IW-1:0] mask_idx;
    logic [IW-1:0] dig_idx;
    logic [IW-1:0] an_base;
    logic [IW-1:0] ck_idx;
    logic [IW-1:0] addr_sh;
    logic [IW-1:0] an_off;
    logic [15:0]   frame_len;
    logic [15:0]   dig_clean;
    logic          dig_present;
    logic [2:0]    n_an;

    // fixed fields shift down by six bytes for the short address
    assign rssi_idx = smp.is64 ? OFS_RSSI64 : OFS_RSSI16;
    assign opt_idx  = rssi_idx + 6'h01;
    assign cnt_idx  = rssi_idx + 6'h02;
    assign mask_idx = rssi_idx + 6'h03;
    assign dig_idx  = smp.is64 ? OFS_DIG64 : OFS_DIG16;
    assign dig_present = |smp.chan_mask[DIG_LSB +: DIG_W];
    assign dig_clean   = {7'h00, smp.dig_word[DIG_LSB +: DIG_W]
                          & smp.chan_mask[DIG_LSB +: DIG_W]};
    // analog start moves down two bytes, to dig_idx, when the digital word is omitted
    assign an_base = dig_present ? (smp.is64 ? OFS_AN64 : OFS_AN16)
                                 : dig_idx;
    assign ck_idx  = an_base + {2'b00, n_an, 1'b0};
    assign frame_len = {10'h000, ck_idx - OFS_TYPE};
    assign addr_sh = (rssi_idx - 6'h01) - idx;
    assign an_off  = idx - an_base;

    // ********************************
    // analog channel rank by enabled position
    // ********************************
    logic [2:0]  rank  [AN_N+1];
    logic [15:0] an_acc[AN_N+1];
    logic [15:0] an_word;
    assign rank[0]   = 3'd0;
    assign an_acc[0] = 16'h0000;

    // the k-th analog word goes to the k-th enabled channel, lowest first
    for (genvar c = 0; c < AN_N; c++) begin : g_an
        logic en;
        logic hit;
        assign en  = smp.chan_mask[AN_LSB + c];
        assign hit = en && (rank[c] == an_off[3:1]);
        assign rank[c+1] = rank[c] + {2'b00, en};
        // upper six bits forced zero
        assign an_acc[c+1] = an_acc[c] |
            (hit ? {6'h00, smp.adc[c]} : 16'h0000);
    end
    assign n_an    = rank[AN_N];
    assign an_word = an_acc[AN_N];

    // ********************************
    // byte selection
    // ********************************
    logic [7:0] ck_byte;
    logic [7:0] opt_byte;
    logic [7:0] addr_byte;
    logic [7:0] next_byte;
    logic [63:0] addr_shifted;

    assign opt_byte = {5'h00, smp.pan_bcast, smp.addr_bcast, 1'b0};
    assign addr_shifted = smp.src_addr >> {addr_sh, 3'b000};
    assign addr_byte    = addr_shifted[7:0];

    // every field msb first; checksum last
    assign next_byte =
        (idx == OFS_SOF)      ? SOF_BYTE :
        (idx == OFS_LENH)     ? frame_len[15:8] :
        (idx == OFS_LENL)     ? frame_len[7:0] :
        (idx == OFS_TYPE)     ? (smp.is64 ? TYPE_A64 : TYPE_A16) :
        (idx <  rssi_idx)     ? addr_byte :
        (idx == rssi_idx)     ? smp.rssi_mag :
        (idx == opt_idx)      ? opt_byte :
        (idx == cnt_idx)      ? smp.nsamples :
        (idx == mask_idx)     ? smp.chan_mask[15:8] :
        (idx == mask_idx + 6'h01) ? smp.chan_mask[7:0] :
        (idx <  an_base)      ? ((idx == dig_idx) ? dig_clean[15:8]
                                                  : dig_clean[7:0]) :
        (idx <  ck_idx)       ? (an_off[0] ? an_word[7:0]
                                           : an_word[15:8]) :
        ck_byte;

    // ********************************
    // sequencing
    // ********************************
    assign load = (state == ST_SEND) && slot_free && (idx <= ck_idx);
    assign fin  = (state == ST_SEND) && slot_free && (idx >  ck_idx);

    // checksum spans the type byte up to the byte before it
    iof_cksum u_cksum (
        .mclk    (mclk),
        .srst    (srst),
        .clr     (accept),
        .add     (load && (idx >= OFS_TYPE) && (idx < ck_idx)),
        .din     (next_byte),
        .ck_byte (ck_byte)
    );

    // capture the sample set; it stays stable for the whole frame
    always_ff @(posedge mclk) begin
        if (accept) begin
            smp <= smp_in;
        end
    end

    // state and byte index
    always_ff @(posedge mclk) begin
        if (srst) begin
            state <= ST_IDLE;
            idx   <= '0;
        end else if (accept) begin
            state <= ST_SEND;
            idx   <= '0;
        end else if (load) begin
            idx   <= idx + 6'h01;
        end else if (fin) begin
            state <= ST_IDLE;
        end
    end

    // output byte register; held while the uart stalls
    always_ff @(posedge mclk) begin
        if (srst) begin
            tx <= '0;
        end else if (load) begin
            tx.valid <= 1'b1;
            tx.data  <= next_byte;
        end else if (tx_ready) begin
            tx.valid <= 1'b0;
        end
    end

    // ********************************
    // assertions
    // ********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    a_frame_start: assert property (
        accept |-> ##2 (tx.valid && tx.data == SOF_BYTE))
        else $error("frame does not open with delimiter");
    a_type_code: assert property (
        load && idx == OFS_TYPE |=>
            tx.data == (smp.is64 ? TYPE_A64 : TYPE_A16))
        else $error("wrong frame type code");
    a_addr_msb: assert property (
        load && idx == OFS_ADDR |=> tx.data ==
            (smp.is64 ? smp.src_addr[63:56] : smp.src_addr[15:8]))
        else $error("address not msb first");
    a_rssi_place: assert property (
        load && idx == (smp.is64 ? 6'd12 : 6'd6) |=>
            tx.data == smp.rssi_mag)
        else $error("signal strength misplaced");
    a_opt_resv: assert property (
        load && idx == opt_idx |=> tx.data[0] == 1'b0 &&
            tx.data[7:3] == 5'h00 && tx.data[2] == smp.pan_bcast)
        else $error("options byte wrong");
    a_count_byte: assert property (
        load && smp.is64 && idx == 6'd14 |=> tx.data == smp.nsamples)
        else $error("sample count misplaced");
    a_dig_zero: assert property (
        load && !dig_present |-> idx != dig_idx || an_base == dig_idx)
        else $error("digital word not omitted");
    a_an_upper: assert property (
        load && idx >= an_base && idx < ck_idx && !an_off[0] |=>
            tx.data[7:2] == 6'h00)
        else $error("analog upper bits not zero");
    a_len_field: assert property (
        load && idx == OFS_LENL |=> tx.data == frame_len[7:0])
        else $error("length field wrong");
    a_stall_hold: assert property (
        tx.valid && !tx_ready |=> tx.valid && $stable(tx.data))
        else $error("byte dropped under stall");

    c_frame_64: cover property (accept && smp_in.is64);
    c_frame_16: cover property (accept && !smp_in.is64);
    c_no_dig: cover property (fin && !dig_present && n_an != 3'd0);
endmodule

// >>> test/iof_host_model.sv
// host model: uart-side byte sink, paced at full rate or stalling
module iof_host_model (
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               srst,
    // byte stream from the builder
    input  wire iof_pkg::iof_byte_t tx,
    output logic                    tx_ready,
    // pacing and capture
    input  wire logic               slow,
    output logic                    got
);
    timeunit 1ns;
    timeprecision 1ns;
    import iof_pkg::*;
    // ********************************
    // pacing
    // ********************************
    logic [1:0] pace;
    // slow mode is ready one cycle in four, so held bytes get exercised
    always_ff @(posedge mclk) begin
        if (srst) begin
            pace     <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            pace     <= pace + 2'h1;
            tx_ready <= !slow || (pace == 2'h3);
        end
    end
    // a byte is handed off on any edge with both sides high
    assign got = tx.valid && tx_ready;
endmodule

// >>> test/testbench.sv
// testbench: frames from sample sets checked byte by byte
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import iof_pkg::*;
    // ********************************
    // clock, design, host
    // ********************************
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        smp_valid = 1'b0;
    logic        smp_ready;
    logic        slow = 1'b0;
    logic        got;
    logic        tx_ready;
    iof_sample_t smp_in = '0;
    iof_byte_t   tx;
    int          errors = 0;
    int          cmp_count = 0;
    logic [7:0]  rxq[$];
    initial forever #50 mclk = ~mclk;
    iof_frame_builder dut (.mclk(mclk), .srst(srst), .smp_in(smp_in),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .tx(tx),
        .tx_ready(tx_ready));
    iof_host_model host (.mclk(mclk), .srst(srst), .tx(tx),
        .tx_ready(tx_ready), .slow(slow), .got(got));
    // capture every handed-off byte
    always @(posedge mclk) begin
        if (got) rxq.push_back(tx.data);
    end
    // ********************************
    // helpers
    // ********************************
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // expected frame worked out from the sample set
    function automatic void build(iof_sample_t s, ref logic [7:0] f[$]);
        logic [7:0] d[$];
        logic [7:0] ck;
        logic [15:0] dw;
        d.push_back(s.is64 ? 8'h82 : 8'h83);
        for (int i = (s.is64 ? 7 : 1); i >= 0; i--)
            d.push_back(s.src_addr[i*8 +: 8]);
        d.push_back(s.rssi_mag);
        d.push_back({5'h0, s.pan_bcast, s.addr_bcast, 1'b0});
        d.push_back(s.nsamples);
        d.push_back(s.chan_mask[15:8]);
        d.push_back(s.chan_mask[7:0]);
        dw = {7'h0, s.dig_word[8:0] & s.chan_mask[8:0]};
        if (|s.chan_mask[8:0]) begin
            d.push_back(dw[15:8]);
            d.push_back(dw[7:0]);
        end
        for (int c = 0; c < 4; c++)
            if (s.chan_mask[9+c]) begin
                d.push_back({6'h0, s.adc[c][9:8]});
                d.push_back(s.adc[c][7:0]);
            end
        ck = 8'hff;
        foreach (d[i]) ck -= d[i];
        f = {8'h7e, 8'h00, 8'(d.size()), d, ck};
    endfunction
    // offer one sample set, collect its frame and compare it whole
    task automatic run_frame(iof_sample_t s, logic pace_slow);
        logic [7:0] f[$];
        int n;
        build(s, f);
        rxq.delete();
        slow <= pace_slow;
        smp_in <= s;
        smp_valid <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (!smp_ready && n < 300);
        smp_valid <= 1'b0;
        @(posedge mclk);
        chk("ready low after accept", smp_ready, 1'b0);
        n = 0;
        while ((rxq.size() < f.size() || !smp_ready) && n < 400) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 400) begin
            errors++;
            stop_test();
        end
        chk("frame length", rxq.size(), f.size());
        foreach (f[i]) chk($sformatf("byte %0d", i), rxq[i], f[i]);
        $display("frame done: %0d bytes", f.size());
    endtask
    // ********************************
    // scenarios
    // ********************************
    task automatic t_wide_digital();
        iof_sample_t s = '0;
        s.is64 = 1'b1;
        s.src_addr = 64'h0123456789abcdef;
        s.rssi_mag = 8'h28;
        s.addr_bcast = 1'b1;
        s.nsamples = 8'h01;
        s.chan_mask = 16'h0101;
        s.dig_word = 16'hffff; // disabled lines must read zero
        run_frame(s, 1'b0);
    endtask
    task automatic t_wide_all_slow();
        iof_sample_t s = '0;
        s.is64 = 1'b1;
        s.src_addr = 64'hfedcba9876543210;
        s.rssi_mag = 8'h5a;
        s.pan_bcast = 1'b1;
        s.nsamples = 8'h01;
        s.chan_mask = 16'hffff;
        s.dig_word = 16'h1a5;
        s.adc = {10'h3ff, 10'h200, 10'h155, 10'h001};
        run_frame(s, 1'b1);
    endtask
    task automatic t_short_analog_only();
        iof_sample_t s = '0;
        s.src_addr = 64'h000000000000beef;
        s.rssi_mag = 8'h64;
        s.addr_bcast = 1'b1;
        s.pan_bcast = 1'b1;
        s.nsamples = 8'h02;
        s.chan_mask = 16'h1400; // analog 1 and 3, no digital word
        s.dig_word = 16'h01ff;
        s.adc = {10'h2aa, 10'h0f0, 10'h11f, 10'h3c3};
        run_frame(s, 1'b0);
    endtask
    task automatic t_short_back_to_back();
        iof_sample_t s = '0;
        s.src_addr = 64'h0000000000001234;
        s.nsamples = 8'h03;
        s.chan_mask = 16'h03fe;
        s.dig_word = 16'h0155;
        s.adc = {10'h000, 10'h000, 10'h000, 10'h3ff};
        run_frame(s, 1'b1);
        s.chan_mask = 16'h0000; // empty mask: header and checksum only
        run_frame(s, 1'b0);
    endtask
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        t_wide_digital();
        t_wide_all_slow();
        t_short_analog_only();
        t_short_back_to_back();
        stop_test();
    end
endmodule
